// file: rtl/rcm_pkg.sv
package rcm_pkg;

    // ********************************
    // calibration control byte layout
    // ********************************
    localparam int FLAG_PWR = 0;
    localparam int FLAG_TIME = 1;
    localparam int FLAG_SLOT = 2;
    localparam int FLAG_FREQ = 3;
    localparam int FLAG_W = 4;

    // ********************************
    // field byte counts, last index
    // ********************************
    localparam logic [1:0] TIME_LAST = 2'h1;
    localparam logic [1:0] PWR_LAST = 2'h0;
    localparam logic [1:0] SLOT_LAST = 2'h1;
    localparam logic [1:0] FREQ_LAST = 2'h3;
    localparam int SLOT_BITS = 13;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TIME_UNIT_NS = 100;
    // nearest whole cycle per step of the time offset
    localparam int TIME_UNIT_CYCLES = (TIME_UNIT_NS * 1000 + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;

    // ********************************
    // reset and limit values
    // ********************************
    localparam logic [7:0] PWR_RESET = 8'h00;
    localparam logic [7:0] PWR_MAX = 8'hff;

    // ********************************
    // capability word layout
    // ********************************
    localparam int CAP_ENCAP_LSB = 24;
    localparam int CAP_US_LSB = 16;
    localparam int CAP_DS_LSB = 12;
    localparam int CAP_RR_BIT = 6;
    localparam int CAP_FRAG_BIT = 5;
    localparam int CAP_SEC_BIT = 4;
    localparam int CAP_MINI_BIT = 3;
    localparam int CAP_IB_BIT = 1;
    localparam int CAP_OOB_BIT = 0;
    localparam int US_RATE_LSB = 2;
    localparam logic [31:0] CAP_VALID_MASK = 32'h070c_107b;
    localparam logic [31:0] CAP_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        RCM_IDLE = 3'b000,
        RCM_TIME = 3'b001,
        RCM_PWR = 3'b010,
        RCM_SLOT = 3'b011,
        RCM_FREQ = 3'b100,
        RCM_REPLY = 3'b101
    } rcm_state_e;

endpackage

// file: rtl/rcm_cap_word.sv
`timescale 1ns/1ps
module rcm_cap_word (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [2:0] encap_flags_i,
    input wire logic [1:0] upstream_rate_flags_i,
    input wire logic downstream_side_channel_rate_flags_i,
    input wire logic resource_request_capable_i,
    input wire logic fragmentation_supported_i,
    input wire logic security_supported_i,
    input wire logic minislots_capable_i,
    input wire logic in_band_signalling_capable_i,
    input wire logic side_channel_signalling_capable_i,
    output logic [31:0] terminal_capability_word_o
);

    typedef struct packed {
        logic [31:0] word;
    } rcm_cap_s;

    rcm_cap_s s_reg;
    rcm_cap_s s_next;

    // ********************************
    // word assembly
    // ********************************
    always_comb begin
        s_next.word = '0;
        // RULE2 encapsulation flags
        s_next.word[rcm_pkg::CAP_ENCAP_LSB +: 3] = encap_flags_i;
        // RULE3 upstream rate flags
        s_next.word[rcm_pkg::CAP_US_LSB + rcm_pkg::US_RATE_LSB +: 2] = upstream_rate_flags_i;
        // RULE4 side channel rate
        s_next.word[rcm_pkg::CAP_DS_LSB] = downstream_side_channel_rate_flags_i;
        // RULE5 resource request flag
        s_next.word[rcm_pkg::CAP_RR_BIT] = resource_request_capable_i;
        // RULE6 fragmentation flag
        s_next.word[rcm_pkg::CAP_FRAG_BIT] = fragmentation_supported_i;
        // RULE7 single capability flags
        s_next.word[rcm_pkg::CAP_SEC_BIT] = security_supported_i;
        s_next.word[rcm_pkg::CAP_MINI_BIT] = minislots_capable_i;
        s_next.word[rcm_pkg::CAP_IB_BIT] = in_band_signalling_capable_i;
        s_next.word[rcm_pkg::CAP_OOB_BIT] = side_channel_signalling_capable_i;
        // RULE20 reserved bits zero
        s_next.word = s_next.word & rcm_pkg::CAP_VALID_MASK;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_reg.word <= rcm_pkg::CAP_RESET;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign terminal_capability_word_o = s_reg.word;

endmodule

// file: rtl/rcm_handler.sv
// Notes on behaviour
// RULE1 - capability word of 32 bits is offered for the sign-on reply
// RULE2 - encapsulation byte: direct IP, bridging, PPP in bits 0..2, rest reserved
// RULE3 - upstream rate byte: bit 2 low rate, bit 3 double rate, rest reserved
// RULE4 - side channel rate nibble: bit 0 low rate, rest reserved
// RULE5 - resource request flag set only when such requests can be sent
// RULE6 - fragmentation flag set only when 512 byte compound fields are handled
// RULE7 - separate flags for security, minislots, in-band and side channel signalling
// RULE8 - first message byte: bit 3 freq, 2 slot, 1 time, 0 power present
// RULE9 - 16-bit signed time step of 100 ns; positive moves transmission earlier
// RULE10 - time step rounded to whole cycles of the existing clock
// RULE11 - signed power byte times half dB added to current power level
// RULE12 - 32-bit signed frequency offset in hertz loaded and retune strobed
// RULE13 - slot flag set: reply in given slot; clear: ordinary ranging slot
// RULE14 - only the 13 low bits of the slot number are used
// RULE15 - head end places the slot in reservation area with free neighbours
// RULE16 - ranging replies never go out in minislots
// RULE17 - every calibration message produces one reply; a message cut off by a new first byte gets none
// RULE18 - reply byte is the unsigned actual transmit power in half dB steps
// RULE19 - fields follow flag byte: time, power, slot, frequency, high byte first
// RULE20 - reserved capability bits sent as zero, reserved flag bits ignored
`timescale 1ns/1ps
module rcm_handler #(
    parameter int TADV_W = 24
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic msg_valid_i,
    input wire logic msg_first_i,
    input wire logic [7:0] msg_byte_i,
    input wire logic power_load_i,
    input wire logic [7:0] power_load_value_i,
    input wire logic [2:0] encap_flags_i,
    input wire logic [1:0] upstream_rate_flags_i,
    input wire logic downstream_side_channel_rate_flags_i,
    input wire logic resource_request_capable_i,
    input wire logic fragmentation_supported_i,
    input wire logic security_supported_i,
    input wire logic minislots_capable_i,
    input wire logic in_band_signalling_capable_i,
    input wire logic side_channel_signalling_capable_i,
    output logic [31:0] terminal_capability_word_o,
    output logic busy_o,
    output logic reply_valid_o,
    output logic [7:0] reply_power_o,
    output logic [rcm_pkg::SLOT_BITS-1:0] reply_slot_o,
    output logic reply_slot_assigned_o,
    output logic reply_minislot_o,
    output logic signed [TADV_W-1:0] tx_advance_o,
    output logic time_adjusted_o,
    output logic [7:0] power_level_o,
    output logic signed [31:0] freq_offset_o,
    output logic freq_retune_o
);

    // ********************************
    // parameter check
    // ********************************
    // a full 16-bit step times the cycle count needs 21 bits plus headroom
    generate
        if (TADV_W < 22 || TADV_W > 32) begin : g_bad_width
            $error("TADV_W must be 22 to 32");
        end
    endgenerate

    typedef struct packed {
        rcm_pkg::rcm_state_e st;
        logic [rcm_pkg::FLAG_W-1:0] flags;
        logic [1:0] cnt;
        logic [31:0] shift;
        logic signed [TADV_W-1:0] tadv;
        logic tadj;
        logic [7:0] pwr;
        logic [rcm_pkg::SLOT_BITS-1:0] slot;
        logic slot_sel;
        logic signed [31:0] freq;
        logic retune;
        logic rvalid;
        logic [7:0] rpower;
        logic [rcm_pkg::SLOT_BITS-1:0] rslot;
        logic rsel;
        logic busy;
        logic minislot;
    } rcm_state_s;

    rcm_state_s s_reg;
    rcm_state_s s_next;

    // ********************************
    // field order
    // ********************************
    function automatic rcm_pkg::rcm_state_e pick_next(input logic [rcm_pkg::FLAG_W-1:0] f);
        rcm_pkg::rcm_state_e r;
        r = rcm_pkg::RCM_REPLY;
        // RULE19 field order
        if (f[rcm_pkg::FLAG_TIME]) begin
            r = rcm_pkg::RCM_TIME;
        end else if (f[rcm_pkg::FLAG_PWR]) begin
            r = rcm_pkg::RCM_PWR;
        end else if (f[rcm_pkg::FLAG_SLOT]) begin
            r = rcm_pkg::RCM_SLOT;
        end else if (f[rcm_pkg::FLAG_FREQ]) begin
            r = rcm_pkg::RCM_FREQ;
        end
        return r;
    endfunction

    logic [15:0] field16;
    logic signed [TADV_W-1:0] time_step;
    logic signed [9:0] pwr_sum;
    logic [7:0] pwr_clamped;

    // ********************************
    // arithmetic on the incoming field
    // ********************************
    always_comb begin
        field16 = {s_reg.shift[7:0], msg_byte_i};
        // RULE10 whole cycle step
        time_step = TADV_W'($signed(field16)) * $signed(TADV_W'(rcm_pkg::TIME_UNIT_CYCLES));
        // RULE11 half dB addition
        pwr_sum = $signed({2'b00, s_reg.pwr}) + $signed({{2{msg_byte_i[7]}}, msg_byte_i});
        // saturate rather than wrap so a large step never flips to the opposite end
        if (pwr_sum < 0) begin
            pwr_clamped = rcm_pkg::PWR_RESET;
        end else if (pwr_sum > $signed({2'b00, rcm_pkg::PWR_MAX})) begin
            pwr_clamped = rcm_pkg::PWR_MAX;
        end else begin
            pwr_clamped = pwr_sum[7:0];
        end
    end

    // ********************************
    // message parser
    // ********************************
    always_comb begin
        s_next = s_reg;
        s_next.tadj = 1'b0;
        s_next.retune = 1'b0;
        s_next.rvalid = 1'b0;
        if (power_load_i && s_reg.st == rcm_pkg::RCM_IDLE) begin
            s_next.pwr = power_load_value_i;
        end
        unique case (s_reg.st)
            rcm_pkg::RCM_IDLE: begin
            end
            rcm_pkg::RCM_REPLY: begin
                // RULE17 one reply per message
                s_next.rvalid = 1'b1;
                // RULE18 actual power reported
                s_next.rpower = s_reg.pwr;
                s_next.rslot = s_reg.slot;
                s_next.rsel = s_reg.slot_sel;
                s_next.st = rcm_pkg::RCM_IDLE;
            end
            rcm_pkg::RCM_TIME, rcm_pkg::RCM_PWR, rcm_pkg::RCM_SLOT, rcm_pkg::RCM_FREQ: begin
                if (msg_valid_i && !msg_first_i) begin
                    // RULE19 high byte first
                    s_next.shift = {s_reg.shift[23:0], msg_byte_i};
                    s_next.cnt = s_reg.cnt + 2'h1;
                    unique case (s_reg.st)
                        rcm_pkg::RCM_TIME: begin
                            if (s_reg.cnt == rcm_pkg::TIME_LAST) begin
                                // RULE9 positive step transmits earlier
                                s_next.tadv = s_reg.tadv + time_step;
                                s_next.tadj = 1'b1;
                                s_next.flags[rcm_pkg::FLAG_TIME] = 1'b0;
                            end
                        end
                        rcm_pkg::RCM_PWR: begin
                            if (s_reg.cnt == rcm_pkg::PWR_LAST) begin
                                // RULE11 power update
                                s_next.pwr = pwr_clamped;
                                s_next.flags[rcm_pkg::FLAG_PWR] = 1'b0;
                            end
                        end
                        rcm_pkg::RCM_SLOT: begin
                            if (s_reg.cnt == rcm_pkg::SLOT_LAST) begin
                                // RULE14 low 13 bits only
                                s_next.slot = field16[rcm_pkg::SLOT_BITS-1:0];
                                // RULE13 assigned slot used
                                s_next.slot_sel = 1'b1;
                                s_next.flags[rcm_pkg::FLAG_SLOT] = 1'b0;
                            end
                        end
                        default: begin
                            if (s_reg.cnt == rcm_pkg::FREQ_LAST) begin
                                // RULE12 frequency retune
                                s_next.freq = {s_reg.shift[23:0], msg_byte_i};
                                s_next.retune = 1'b1;
                                s_next.flags[rcm_pkg::FLAG_FREQ] = 1'b0;
                            end
                        end
                    endcase
                    if (s_next.flags != s_reg.flags) begin
                        s_next.cnt = 2'h0;
                        s_next.st = pick_next(s_next.flags);
                    end
                end
            end
            default: begin
                s_next.st = rcm_pkg::RCM_IDLE;
            end
        endcase
        // a new first byte aborts any field in progress
        if (msg_valid_i && msg_first_i) begin
            // RULE8 flag decode
            // RULE20 reserved flag bits dropped
            s_next.flags = msg_byte_i[rcm_pkg::FLAG_W-1:0];
            s_next.cnt = 2'h0;
            s_next.shift = '0;
            // RULE13 default to ordinary slot
            s_next.slot_sel = 1'b0;
            s_next.slot = '0;
            s_next.st = pick_next(msg_byte_i[rcm_pkg::FLAG_W-1:0]);
        end
        // busy kept in its own flop so the output leaves a register, not a compare
        s_next.busy = (s_next.st != rcm_pkg::RCM_IDLE);
        // RULE16 no minislot ranging
        s_next.minislot = 1'b0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_reg <= '0;
            s_reg.st <= rcm_pkg::RCM_IDLE;
            s_reg.pwr <= rcm_pkg::PWR_RESET;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // ********************************
    // capability word
    // ********************************
    // RULE1 capability word
    rcm_cap_word u_cap (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .encap_flags_i(encap_flags_i),
        .upstream_rate_flags_i(upstream_rate_flags_i),
        .downstream_side_channel_rate_flags_i(downstream_side_channel_rate_flags_i),
        .resource_request_capable_i(resource_request_capable_i),
        .fragmentation_supported_i(fragmentation_supported_i),
        .security_supported_i(security_supported_i),
        .minislots_capable_i(minislots_capable_i),
        .in_band_signalling_capable_i(in_band_signalling_capable_i),
        .side_channel_signalling_capable_i(side_channel_signalling_capable_i),
        .terminal_capability_word_o(terminal_capability_word_o)
    );

    // ********************************
    // outputs
    // ********************************
    assign busy_o = s_reg.busy;
    assign reply_valid_o = s_reg.rvalid;
    assign reply_power_o = s_reg.rpower;
    assign reply_slot_o = s_reg.rslot;
    assign reply_slot_assigned_o = s_reg.rsel;
    // RULE16 no minislot ranging
    assign reply_minislot_o = s_reg.minislot;
    assign tx_advance_o = s_reg.tadv;
    assign time_adjusted_o = s_reg.tadj;
    assign power_level_o = s_reg.pwr;
    assign freq_offset_o = s_reg.freq;
    assign freq_retune_o = s_reg.retune;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    logic field_byte;
    assign field_byte = ce_i && msg_valid_i && !msg_first_i;

    empty_msg_reply_a: assert property ( // RULE17
        ce_i && msg_valid_i && msg_first_i && msg_byte_i[3:0] == 4'h0 ##1 ce_i |=> reply_valid_o
    ) else $error("no reply for message without fields");

    reply_power_match_a: assert property ( // RULE18
        reply_valid_o |-> reply_power_o == power_level_o
    ) else $error("reply power differs from power level");

    no_minislot_a: assert property ( // RULE16
        reply_minislot_o == 1'b0
    ) else $error("ranging reply flagged for minislot");

    time_first_a: assert property ( // RULE19
        ce_i && msg_valid_i && msg_first_i && msg_byte_i[rcm_pkg::FLAG_TIME] |=> s_reg.st == rcm_pkg::RCM_TIME
    ) else $error("time field not parsed first");

    flag_ignore_a: assert property ( // RULE8
        ce_i && msg_valid_i && msg_first_i |=> s_reg.flags == $past(msg_byte_i[3:0])
    ) else $error("flag byte decoded wrongly");

    time_step_a: assert property ( // RULE9
        field_byte && s_reg.st == rcm_pkg::RCM_TIME && s_reg.cnt == 2'h1
        |=> time_adjusted_o && tx_advance_o == $past(tx_advance_o) + $past(time_step)
    ) else $error("time advance not updated by the step");

    power_step_a: assert property ( // RULE11
        field_byte && s_reg.st == rcm_pkg::RCM_PWR
        |=> power_level_o == $past(pwr_clamped) && s_reg.st != rcm_pkg::RCM_PWR
    ) else $error("power level not updated");

    slot_mask_a: assert property ( // RULE14
        field_byte && s_reg.st == rcm_pkg::RCM_SLOT && s_reg.cnt == 2'h1
        |=> s_reg.slot == $past(field16[12:0]) && s_reg.slot_sel
    ) else $error("slot number not masked to 13 bits");

    freq_retune_a: assert property ( // RULE12
        freq_retune_o && $past(ce_i)
        |-> $past(s_reg.st) == rcm_pkg::RCM_FREQ
            && freq_offset_o == {$past(s_reg.shift[23:0]), $past(msg_byte_i)}
    ) else $error("retune without full frequency field");

    ordinary_slot_a: assert property ( // RULE13
        reply_valid_o && !reply_slot_assigned_o |-> reply_slot_o == '0
    ) else $error("ordinary slot reply carries a slot number");

    cap_reserved_a: assert property ( // RULE20
        (terminal_capability_word_o & ~rcm_pkg::CAP_VALID_MASK) == 32'h0000_0000
    ) else $error("reserved capability bit set");

    reply_single_a: assert property ( // RULE17
        reply_valid_o && !busy_o && ce_i |=> !reply_valid_o
    ) else $error("reply pulse repeated without a new message");

    tx_hold_a: assert property ( // RULE9
        !time_adjusted_o && !$past(srst_i) |-> $stable(tx_advance_o)
    ) else $error("time advance moved without an adjustment");

    freq_hold_a: assert property ( // RULE12
        !freq_retune_o && !$past(srst_i) |-> $stable(freq_offset_o)
    ) else $error("frequency offset moved without a retune");

    pwr_load_busy_a: assert property ( // RULE11
        ce_i && power_load_i && busy_o && !(field_byte && s_reg.st == rcm_pkg::RCM_PWR)
        |=> $stable(power_level_o)
    ) else $error("power level loaded while a message is in flight");

    assigned_reply_c: cover property (reply_valid_o && reply_slot_assigned_o);
    retune_c: cover property (freq_retune_o);
    power_top_c: cover property (reply_valid_o && reply_power_o == rcm_pkg::PWR_MAX);
    time_move_c: cover property (time_adjusted_o ##[1:20] reply_valid_o);

endmodule

// file: tb/rcm_head_end_model.sv
`timescale 1ns/1ps
module rcm_head_end_model (
    input wire logic ref_clk_i,
    output logic msg_valid_o,
    output logic msg_first_o,
    output logic [7:0] msg_byte_o
);
    // ********
    // message sender
    // ********
    initial begin
        msg_valid_o = 1'b0;
        msg_first_o = 1'b0;
        msg_byte_o = 8'h00;
    end

    // fields sent in order, high byte first
    // released byte shows the inverse, so a stale byte never passes for data
    task automatic send(input logic [7:0] q[$], input int gap);
        int i;
        for (i = 0; i < q.size(); i++) begin
            msg_valid_o <= 1'b1;
            msg_first_o <= (i == 0);
            msg_byte_o <= q[i];
            @(posedge ref_clk_i);
            if (i == q.size() - 1 || gap > 0) begin
                msg_valid_o <= 1'b0;
                msg_first_o <= 1'b0;
                msg_byte_o <= ~q[i];
                if (i < q.size() - 1) begin
                    repeat (gap) @(posedge ref_clk_i);
                end
            end
        end
    endtask
endmodule

// file: tb/tb_ranging_calibration_msg_handler.sv
`timescale 1ns/1ps
module tb_ranging_calibration_msg_handler;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic msg_valid;
    logic msg_first;
    logic [7:0] msg_byte;
    logic power_load = 1'b0;
    logic [7:0] power_val = 8'h00;
    logic [2:0] encap = 3'h0;
    logic [1:0] us_rate = 2'h0;
    // ds, rr, frag, sec, mini, ib, oob
    logic [6:0] one_bit = 7'h00;
    logic [31:0] cap_word;
    logic busy;
    logic reply_valid;
    logic [7:0] reply_power;
    logic [rcm_pkg::SLOT_BITS-1:0] reply_slot;
    logic slot_asg;
    logic minislot;
    logic signed [23:0] tx_adv;
    logic time_adj;
    logic [7:0] power_level;
    logic signed [31:0] freq;
    logic retune;
    int n_fail = 0;
    int total_checks = 0;
    int n_rep = 0;
    int n_tadj = 0;
    int n_fret = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    rcm_handler #(.TADV_W(24)) dut_u (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .msg_valid_i(msg_valid), .msg_first_i(msg_first), .msg_byte_i(msg_byte),
        .power_load_i(power_load), .power_load_value_i(power_val),
        .encap_flags_i(encap), .upstream_rate_flags_i(us_rate),
        .downstream_side_channel_rate_flags_i(one_bit[6]), .resource_request_capable_i(one_bit[5]),
        .fragmentation_supported_i(one_bit[4]), .security_supported_i(one_bit[3]),
        .minislots_capable_i(one_bit[2]), .in_band_signalling_capable_i(one_bit[1]),
        .side_channel_signalling_capable_i(one_bit[0]), .terminal_capability_word_o(cap_word),
        .busy_o(busy), .reply_valid_o(reply_valid), .reply_power_o(reply_power),
        .reply_slot_o(reply_slot), .reply_slot_assigned_o(slot_asg), .reply_minislot_o(minislot),
        .tx_advance_o(tx_adv), .time_adjusted_o(time_adj), .power_level_o(power_level),
        .freq_offset_o(freq), .freq_retune_o(retune)
    );

    rcm_head_end_model head_u (
        .ref_clk_i(ref_clk_i), .msg_valid_o(msg_valid), .msg_first_o(msg_first), .msg_byte_o(msg_byte)
    );

    // pulses are counted so a doubled or missing one is seen
    always @(posedge ref_clk_i) begin
        if (reply_valid === 1'b1) n_rep++;
        if (time_adj === 1'b1) n_tadj++;
        if (retune === 1'b1) n_fret++;
    end

    // ********
    // helpers
    // ********
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge ref_clk_i);
    endtask

    task automatic load_power(input logic [7:0] v);
        tick();
        power_load <= 1'b1;
        power_val <= v;
        tick();
        power_load <= 1'b0;
        tick();
        #1;
    endtask

    task automatic wait_reply(input logic [7:0] pwr, input logic [12:0] slot, input logic asg);
        int i;
        int r0;
        r0 = n_rep;
        for (i = 0; i < 20; i++) begin
            tick();
            #1;
            if (reply_valid === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            $display("wrong value at %0t: no reply", $time);
            conclude();
        end else begin
            chk(32'(i), 32'h0, "reply delay");
            chk({31'h0, busy}, 32'h0, "busy at reply");
            chk({31'h0, minislot}, 32'h0, "minislot");
            chk({24'h0, reply_power}, {24'h0, pwr}, "reply power");
            chk({24'h0, power_level}, {24'h0, pwr}, "power level");
            chk({19'h0, reply_slot}, {19'h0, slot}, "reply slot");
            chk({31'h0, slot_asg}, {31'h0, asg}, "slot assigned");
            tick();
            #1;
            chk({31'h0, reply_valid}, 32'h0, "reply pulse");
            chk(32'(n_rep - r0), 32'h1, "reply count");
        end
    endtask

    // ********
    // scenarios
    // ********
    task automatic test_reset();
        tick();
        #1;
        chk(cap_word, 32'h0, "cap at reset");
        chk({24'h0, power_level}, 32'h0, "power at reset");
        chk(freq, 32'h0, "freq at reset");
        $display("test reset done");
    endtask

    task automatic test_cap();
        tick();
        encap <= 3'h7;
        us_rate <= 2'h3;
        one_bit <= 7'h7f;
        tick();
        #1;
        chk(cap_word, 32'h070c_107b, "cap all set");
        tick();
        encap <= 3'h5;
        us_rate <= 2'h2;
        one_bit <= 7'h2a;
        tick();
        #1;
        chk(cap_word, 32'h0508_0052, "cap mixed");
        tick();
        encap <= 3'h0;
        us_rate <= 2'h0;
        one_bit <= 7'h50;
        tick();
        #1;
        chk(cap_word, 32'h0000_1020, "cap ds frag");
        tick();
        ce_i <= 1'b0;
        one_bit <= 7'h00;
        repeat (2) tick();
        #1;
        chk(cap_word, 32'h0000_1020, "cap frozen");
        tick();
        ce_i <= 1'b1;
        $display("test cap done");
    endtask

    task automatic test_power();
        load_power(8'h40);
        chk({24'h0, power_level}, 32'h40, "power load");
        tick();
        head_u.send('{8'h01, 8'h04}, 0);
        wait_reply(8'h44, 13'h0, 1'b0);
        load_power(8'hfe);
        tick();
        head_u.send('{8'h01, 8'h7f}, 0);
        wait_reply(8'hff, 13'h0, 1'b0);
        load_power(8'h02);
        tick();
        head_u.send('{8'h01, 8'h80}, 0);
        wait_reply(8'h00, 13'h0, 1'b0);
        chk({8'h0, tx_adv}, 32'h0, "no time change");
        $display("test power done");
    endtask

    task automatic test_full();
        int t0;
        int f0;
        load_power(8'h10);
        t0 = n_tadj;
        f0 = n_fret;
        tick();
        // a load while busy must not disturb the message in flight
        fork
            head_u.send('{8'hff, 8'h00, 8'h03, 8'hfd, 8'hff, 8'hff, 8'h80, 8'h00, 8'h00, 8'h01}, 1);
            begin
                repeat (3) tick();
                power_load <= 1'b1;
                power_val <= 8'h99;
                tick();
                power_load <= 1'b0;
                #1;
                chk({31'h0, busy}, 32'h1, "busy in message");
                chk({24'h0, power_level}, 32'h10, "load while busy");
            end
        join
        wait_reply(8'h0d, 13'h1fff, 1'b1);
        chk({8'h0, tx_adv}, 32'h3c, "advance earlier");
        chk(freq, 32'h8000_0001, "freq offset");
        chk(32'(n_tadj - t0), 32'h1, "time pulse");
        chk(32'(n_fret - f0), 32'h1, "retune pulse");
        $display("test full done");
    endtask

    task automatic test_abort();
        tick();
        head_u.send('{8'h02, 8'h12}, 0);
        tick();
        head_u.send('{8'h00}, 0);
        wait_reply(8'h0d, 13'h0, 1'b0);
        chk({8'h0, tx_adv}, 32'h3c, "aborted time");
        tick();
        head_u.send('{8'h02, 8'hff, 8'hfe}, 0);
        wait_reply(8'h0d, 13'h0, 1'b0);
        chk({8'h0, tx_adv}, 32'h14, "advance later");
        $display("test abort done");
    endtask

    initial begin
        repeat (3) tick();
        srst_i <= 1'b0;
        test_reset();
        test_cap();
        test_power();
        test_full();
        test_abort();
        conclude();
    end
endmodule
